// ### verilog/lowside_pkg.sv
// Constants, field positions and state codes for the serial low-side link.
// Assumes a 125 MHz pclk shared by both ends of the link.
// Contract
// - Latch low: shift data in on rising clock
// - Last holding stage drives serial data out
// - Latch rising edge copies holding to outputs
// - Over 400 ns from last clock to latch
// - Latch high 200 ns before fault readout
// - Reset high 20 us, then 20 us idle
// - Wait 55 us after supply before clocking
// - Overcurrent over 3.5 us disables channel, flags fault
// - Overcurrent channel retries after about 1.2 ms
// - Reset or supply loss clears overcurrent at once
// - Overtemperature disables all outputs until it clears
// - Undervoltage holds all logic in reset
// - Off channel low sense 15 us sets open-load
// - Overcurrent sets latch; clearing output bit clears it
// - Fault bit is overcurrent OR open-load
// - First falling clock after latch captures faults
// - Later falling clocks shift faults toward output
// - Fault pin low on any latch or overtemperature; code leaves it released on overtemperature during undervoltage
// - Drive enable low gates all outputs
// - Drive enable leaves serial logic untouched
// - Reset clears logic, faults and both registers
// - Internal power-up reset acts like reset
`default_nettype none
package lowside_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CHANNELS      = 4;
    localparam int CHAIN_LEN     = 1;

    localparam int OC_DEGLITCH_NS   = 3500;
    localparam int OL_DEGLITCH_NS   = 15000;
    localparam int RETRY_NS         = 1200000;
    localparam int LATCH_GAP_NS     = 400;
    localparam int LATCH_HOLD_NS    = 200;
    localparam int RESET_PULSE_NS   = 20000;
    localparam int RESET_DELAY_NS   = 20000;
    localparam int STARTUP_NS       = 55000;

    localparam logic [8:0]  OC_CYCLES =
        9'((OC_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [10:0] OL_CYCLES =
        11'((OL_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [17:0] RETRY_CYCLES_DEF =
        18'(RETRY_NS / CLK_PERIOD_NS);
    localparam logic [12:0] LATCH_GAP_CYCLES =
        13'(LATCH_GAP_NS / CLK_PERIOD_NS + 1);
    localparam logic [12:0] LATCH_HOLD_CYCLES =
        13'((LATCH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [12:0] RESET_PULSE_CYCLES =
        13'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [12:0] RESET_DELAY_CYCLES =
        13'((RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [12:0] STARTUP_CYCLES_DEF =
        13'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0]  POR_CYCLES  = 5'h10;
    localparam logic [12:0] HALF_CYCLES = 13'h0008;
    localparam logic [3:0]  TOTAL_BITS  = 4'(CHANNELS * CHAIN_LEN);

    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] WDATA_ADDR  = 12'h004;
    localparam logic [11:0] RDATA_ADDR  = 12'h008;
    localparam logic [11:0] STATUS_ADDR = 12'h00C;
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_RESET_BIT   = 1;
    localparam int CTRL_DRV_OFF_BIT = 2;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_FAULT_BIT   = 1;
    localparam int STAT_READY_BIT   = 2;

    typedef enum logic [2:0] {
        C_POWERUP    = 3'h0,
        C_IDLE       = 3'h1,
        C_RESET      = 3'h2,
        C_RESET_WAIT = 3'h3,
        C_SHIFT      = 3'h4,
        C_GAP        = 3'h5,
        C_HOLD       = 3'h6,
        C_READ       = 3'h7
    } ctl_mode_type;
endpackage
`default_nettype wire

// ### verilog/lowside_if.sv
// Serial link between one low-side switch device and its controller.
// Fault line is open drain with an implied pull-up resolved here.
`timescale 1ns/100ps
`default_nettype none
interface lowside_if;
    logic shift_clock;
    logic latch;
    logic serial_data_in;
    logic chip_reset;
    logic drive_enable_low;
    logic serial_data_out;
    logic fault_n_o;
    logic fault_n_oe;
    wire  fault_indicator_n;

    assign fault_indicator_n = fault_n_oe ? fault_n_o : 1'b1;

    modport device (
        input  shift_clock,
        input  latch,
        input  serial_data_in,
        input  chip_reset,
        input  drive_enable_low,
        output serial_data_out,
        output fault_n_o,
        output fault_n_oe
    );
    modport controller (
        output shift_clock,
        output latch,
        output serial_data_in,
        output chip_reset,
        output drive_enable_low,
        input  serial_data_out,
        input  fault_indicator_n
    );
endinterface
`default_nettype wire

// ### verilog/quad_lowside_device.sv
// Logic of the four-channel low-side switch: serial shift/latch, fault
// capture and readback, overcurrent retry, open-load, shutdowns.
// Assumes all link and sense inputs are asynchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module quad_lowside_device #(
    parameter logic [17:0] RETRY_CYCLES = lowside_pkg::RETRY_CYCLES_DEF
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    lowside_if.device       link,
    input  wire logic [3:0] current_limit,
    input  wire logic [3:0] load_low_sense,
    input  wire logic       over_temp,
    input  wire logic       supply_undervoltage_lockout,
    output logic      [3:0] channel_on
);
    import lowside_pkg::*;

    typedef struct packed {
        logic       uv;
        logic       ot;
        logic [3:0] low_sense;
        logic [3:0] limit;
        logic       drv_off;
        logic       rst;
        logic       sdi;
        logic       lat;
        logic       sck;
    } in_type;

    typedef struct packed {
        in_type           s1;
        in_type           s2;
        logic             sck_q;
        logic             lat_q;
        logic             cap_pend;
        logic [3:0]       shreg;
        logic [3:0]       outreg;
        logic [3:0]       oc;
        logic [3:0]       ol;
        logic [3:0]       drive;
        logic             fault_oe;
        logic [4:0]       por;
        logic [3:0][8:0]  oc_cnt;
        logic [3:0][10:0] ol_cnt;
        logic [3:0][17:0] retry;
    } dev_state_type;

    dev_state_type r;
    dev_state_type n;
    in_type        raw;
    logic          sck_rise;
    logic          sck_fall;
    logic          lat_rise;
    logic          rst_int;
    logic [3:0]    fault_bits;

    assign raw.uv        = supply_undervoltage_lockout;
    assign raw.ot        = over_temp;
    assign raw.low_sense = load_low_sense;
    assign raw.limit     = current_limit;
    assign raw.drv_off   = link.drive_enable_low;
    assign raw.rst       = link.chip_reset;
    assign raw.sdi       = link.serial_data_in;
    assign raw.lat       = link.latch;
    assign raw.sck       = link.shift_clock;

    always_comb begin
        n = r;
        // Two-stage synchroniser; only s2 feeds logic
        n.s1 = raw;
        n.s2 = r.s1;
        n.sck_q = r.s2.sck;
        n.lat_q = r.s2.lat;
        sck_rise = r.s2.sck & ~r.sck_q;
        sck_fall = ~r.s2.sck & r.sck_q;
        lat_rise = r.s2.lat & ~r.lat_q;
        fault_bits = r.oc | r.ol;

        if (r.por != POR_CYCLES) begin
            n.por = r.por + 5'h01;
        end
        rst_int = r.s2.rst | r.s2.uv | (r.por != POR_CYCLES);

        // Serial path runs regardless of the drive enable
        if (!r.s2.lat) begin
            if (sck_rise) begin
                n.shreg = {r.shreg[2:0], r.s2.sdi};
            end
        end else if (sck_fall) begin
            if (r.cap_pend) begin
                n.shreg = fault_bits;
            end else begin
                n.shreg = {r.shreg[2:0], r.s2.sdi};
            end
            n.cap_pend = 1'b0;
        end
        if (lat_rise) begin
            n.outreg = r.shreg;
            n.cap_pend = 1'b1;
        end

        for (int i = 0; i < CHANNELS; i++) begin
            // Overcurrent: clear paths first so a new set wins
            if (r.oc[i]) begin
                if (r.retry[i] == 18'h00000) begin
                    n.oc[i] = 1'b0;
                end else begin
                    n.retry[i] = r.retry[i] - 18'h00001;
                end
            end
            if (!r.outreg[i]) begin
                n.oc[i] = 1'b0;
            end
            if (r.drive[i] && r.s2.limit[i]) begin
                if (r.oc_cnt[i] == OC_CYCLES - 9'h001) begin
                    n.oc[i] = 1'b1;
                    n.retry[i] = RETRY_CYCLES;
                    n.oc_cnt[i] = 9'h000;
                end else begin
                    n.oc_cnt[i] = r.oc_cnt[i] + 9'h001;
                end
            end else begin
                n.oc_cnt[i] = 9'h000;
            end

            // Open load is sensed only while the channel is off
            if (r.outreg[i]) begin
                n.ol[i] = 1'b0;
            end
            if (!r.drive[i] && r.s2.low_sense[i]) begin
                if (r.ol_cnt[i] == OL_CYCLES - 11'h001) begin
                    n.ol[i] = 1'b1;
                    n.ol_cnt[i] = 11'h000;
                end else begin
                    n.ol_cnt[i] = r.ol_cnt[i] + 11'h001;
                end
            end else begin
                n.ol_cnt[i] = 11'h000;
            end

            n.drive[i] = n.outreg[i] & ~n.oc[i] & ~r.s2.ot
                         & ~r.s2.drv_off;
        end

        n.fault_oe = (|n.oc) | (|n.ol) | r.s2.ot;

        if (rst_int) begin
            // Reset, undervoltage and power-up all clear the logic
            n.shreg    = 4'h0;
            n.outreg   = 4'h0;
            n.oc       = 4'h0;
            n.ol       = 4'h0;
            n.drive    = 4'h0;
            n.cap_pend = 1'b0;
            n.oc_cnt   = '0;
            n.ol_cnt   = '0;
            n.retry    = '0;
            n.fault_oe = r.s2.ot & ~r.s2.uv;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign link.serial_data_out = r.shreg[3];
    assign link.fault_n_oe      = r.fault_oe;
    assign link.fault_n_o       = 1'b0;
    assign channel_on           = r.drive;
endmodule
`default_nettype wire

// ### verilog/quad_lowside_controller.sv
// Controller end: APB slave registers order a write-latch-read transfer
// or a reset pulse, and drive the serial link with a divided clock.
// Assumes the device output and fault line are asynchronous to pclk.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module quad_lowside_controller #(
    parameter logic [12:0] STARTUP_CYCLES = lowside_pkg::STARTUP_CYCLES_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    lowside_if.controller    link
);
    import lowside_pkg::*;

    typedef struct packed {
        ctl_mode_type st;
        logic [12:0]  timer;
        logic [3:0]   bitcnt;
        logic         sck;
        logic         lat;
        logic         sdi;
        logic         crst;
        logic         drv_off;
        logic [3:0]   wdata;
        logic [3:0]   wsh;
        logic [3:0]   rsh;
        logic [3:0]   rdata;
        logic         sdo_s1;
        logic         sdo_s2;
        logic         flt_s1;
        logic         flt_s2;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } ctl_state_type;

    ctl_state_type r;
    ctl_state_type n;

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == CTRL_ADDR) || (a == WDATA_ADDR) ||
                   (a == RDATA_ADDR) || (a == STATUS_ADDR);
    endfunction

    always_comb begin
        n = r;
        n.sdo_s1 = link.serial_data_out;
        n.sdo_s2 = r.sdo_s1;
        n.flt_s1 = link.fault_indicator_n;
        n.flt_s2 = r.flt_s1;
        n.pready = 1'b0;
        n.pslverr = 1'b0;

        // Setup phase prepares the answer for a zero-wait access phase
        if (psel && !penable) begin
            n.pready = 1'b1;
            n.pslverr = ~addr_hit(paddr);
            n.prdata = 32'h00000000;
            case (paddr)
                CTRL_ADDR: n.prdata[CTRL_DRV_OFF_BIT] = r.drv_off;
                WDATA_ADDR: n.prdata[3:0] = r.wdata;
                RDATA_ADDR: n.prdata[3:0] = r.rdata;
                STATUS_ADDR: begin
                    n.prdata[STAT_BUSY_BIT]  = r.st != C_IDLE;
                    n.prdata[STAT_FAULT_BIT] = ~r.flt_s2;
                    n.prdata[STAT_READY_BIT] = r.st != C_POWERUP;
                end
                default: n.prdata = 32'h00000000;
            endcase
        end

        case (r.st)
            C_POWERUP: begin
                n.timer = r.timer + 13'h0001;
                if (r.timer == STARTUP_CYCLES) begin
                    n.st = C_IDLE;
                    n.timer = 13'h0000;
                end
            end
            C_IDLE: begin
                n.timer = 13'h0000;
            end
            C_RESET: begin
                n.timer = r.timer + 13'h0001;
                if (r.timer == RESET_PULSE_CYCLES) begin
                    n.crst = 1'b0;
                    n.timer = 13'h0000;
                    n.st = C_RESET_WAIT;
                end
            end
            C_RESET_WAIT: begin
                n.timer = r.timer + 13'h0001;
                if (r.timer == RESET_DELAY_CYCLES) begin
                    n.st = C_IDLE;
                    n.timer = 13'h0000;
                end
            end
            C_SHIFT, C_READ: begin
                n.timer = r.timer + 13'h0001;
                if (r.timer == HALF_CYCLES - 13'h0001) begin
                    n.timer = 13'h0000;
                    if (!r.sck) begin
                        n.sck = 1'b1;
                    end else begin
                        n.sck = 1'b0;
                        n.bitcnt = r.bitcnt + 4'h1;
                        if (r.st == C_SHIFT) begin
                            n.wsh = {r.wsh[2:0], 1'b0};
                            n.sdi = r.wsh[2];
                            if (r.bitcnt == TOTAL_BITS - 4'h1) begin
                                n.st = C_GAP;
                            end
                        end else begin
                            if (r.bitcnt != 4'h0) begin
                                n.rsh = {r.rsh[2:0], r.sdo_s2};
                            end
                            if (r.bitcnt == TOTAL_BITS) begin
                                n.rdata = {r.rsh[2:0], r.sdo_s2};
                                n.lat = 1'b0;
                                n.st = C_IDLE;
                            end
                        end
                    end
                end
            end
            C_GAP: begin
                n.timer = r.timer + 13'h0001;
                if (r.timer == LATCH_GAP_CYCLES) begin
                    n.lat = 1'b1;
                    n.timer = 13'h0000;
                    n.st = C_HOLD;
                end
            end
            C_HOLD: begin
                n.timer = r.timer + 13'h0001;
                if (r.timer == LATCH_HOLD_CYCLES) begin
                    n.timer = 13'h0000;
                    n.bitcnt = 4'h0;
                    n.st = C_READ;
                end
            end
            default: n.st = C_IDLE;
        endcase

        // Write takes effect at the access edge; orders need an idle link
        if (psel && penable && r.pready && pwrite && !r.pslverr) begin
            if (paddr == CTRL_ADDR) begin
                n.drv_off = pwdata[CTRL_DRV_OFF_BIT];
                if (r.st == C_IDLE && pwdata[CTRL_RESET_BIT]) begin
                    n.crst = 1'b1;
                    n.timer = 13'h0000;
                    n.st = C_RESET;
                end else if (r.st == C_IDLE && pwdata[CTRL_START_BIT]) begin
                    n.wsh = r.wdata;
                    n.sdi = r.wdata[3];
                    n.sck = 1'b0;
                    n.bitcnt = 4'h0;
                    n.timer = 13'h0000;
                    n.st = C_SHIFT;
                end
            end else if (paddr == WDATA_ADDR) begin
                n.wdata = pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.drv_off <= 1'b1;
            r.flt_s1 <= 1'b1;
            r.flt_s2 <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign prdata                = r.prdata;
    assign pready                = r.pready;
    assign pslverr               = r.pslverr;
    assign link.shift_clock      = r.sck;
    assign link.latch            = r.lat;
    assign link.serial_data_in   = r.sdi;
    assign link.chip_reset       = r.crst;
    assign link.drive_enable_low = r.drv_off;
endmodule
`default_nettype wire

// ### tb/lowside_link_sva.sv
// Checker for the serial link between the controller and the device.
// Assumes both ends run on pclk and that presetn also resets the link.
`timescale 1ns/100ps
`default_nettype none
module lowside_link_sva
    import lowside_pkg::*;
#(
    parameter logic [12:0] STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic shift_clock,
    input wire logic latch,
    input wire logic serial_data_in,
    input wire logic chip_reset,
    input wire logic drive_enable_low,
    input wire logic serial_data_out,
    input wire logic fault_n_o,
    input wire logic fault_n_oe,
    input wire logic fault_indicator_n
);
    logic        sck_q_r;
    logic        sck_rise;
    logic [12:0] since_rise_r;
    logic [12:0] hold_r;
    logic [12:0] rst_hi_r;
    logic [12:0] idle_r;
    logic [12:0] boot_r;
    logic [3:0]  wr_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign sck_rise = shift_clock & ~sck_q_r;

    // Saturating counters of cycles since link events; wr_r counts shift clock rises while latch is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q_r      <= 1'b0;
            since_rise_r <= 13'h1FFF;
            hold_r       <= 13'h0000;
            rst_hi_r     <= 13'h0000;
            idle_r       <= 13'h1FFF;
            boot_r       <= 13'h0000;
            wr_r         <= 4'h0;
        end else begin
            sck_q_r      <= shift_clock;
            since_rise_r <= sck_rise ? 13'h0000 :
                            since_rise_r + 13'(~&since_rise_r);
            hold_r       <= !latch ? 13'h0000 : hold_r + 13'(~&hold_r);
            rst_hi_r     <= !chip_reset ? 13'h0000 :
                            rst_hi_r + 13'(~&rst_hi_r);
            idle_r       <= chip_reset ? 13'h0000 : idle_r + 13'(~&idle_r);
            boot_r       <= boot_r + 13'(~&boot_r);
            wr_r         <= latch ? 4'h0 : wr_r + 4'(sck_rise);
        end
    end

    property p_sck_half;
        $rose(shift_clock) |-> shift_clock [*8] ##1 !shift_clock;
    endproperty
    a_sck_half: assert property (p_sck_half)
        else $error("shift clock half period wrong");
    property p_sdi_stable;
        shift_clock && $past(shift_clock) |-> $stable(serial_data_in);
    endproperty
    a_sdi_stable: assert property (p_sdi_stable)
        else $error("serial data changed while shift clock high");
    property p_latch_gap;
        $rose(latch) |-> since_rise_r >= LATCH_GAP_CYCLES;
    endproperty
    a_latch_gap: assert property (p_latch_gap)
        else $error("latch rose too soon after last shift edge");
    property p_latch_hold;
        $rose(shift_clock) && latch |-> hold_r >= LATCH_HOLD_CYCLES;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("readback clocked too soon after latch");
    property p_rst_width;
        $fell(chip_reset) |-> rst_hi_r >= RESET_PULSE_CYCLES;
    endproperty
    a_rst_width: assert property (p_rst_width)
        else $error("chip reset pulse too short");
    property p_rst_idle;
        $rose(shift_clock) |-> idle_r >= RESET_DELAY_CYCLES;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("shift clock too soon after chip reset");
    property p_startup;
        $rose(shift_clock) |-> boot_r >= STARTUP_CYCLES;
    endproperty
    a_startup: assert property (p_startup)
        else $error("shift clock too soon after start-up");
    property p_four_bits;
        $rose(latch) |-> wr_r == 4'h4;
    endproperty
    a_four_bits: assert property (p_four_bits)
        else $error("write did not carry four bits");
    property p_rst_clear;
        chip_reset [*5] |-> !serial_data_out;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("serial out not cleared by chip reset");
    property p_fault_pull;
        fault_indicator_n == !(fault_n_oe && !fault_n_o);
    endproperty
    a_fault_pull: assert property (p_fault_pull)
        else $error("fault line level does not follow its driver");
endmodule
`default_nettype wire

// ### tb/quad_lowside_serial_ctrl_tb.sv
// Bench: controller and device joined by the link, driven over APB.
// Assumes a 125 MHz pclk and shortened retry and start-up counts.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module quad_lowside_serial_ctrl_tb;
    import lowside_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  current_limit, load_low_sense, channel_on, rd;
    logic        over_temp, supply_low, drv, e;
    int          bad_count, n_compared, k;
    logic [8:0]  rows [5] = '{9'h0AA, 9'h055, 9'h1F0, 9'h0FF, 9'h000};

    lowside_if link();
    quad_lowside_device #(.RETRY_CYCLES(18'h007D0)) i_quad_lowside_device (
        .pclk(pclk), .presetn(presetn), .link(link),
        .current_limit(current_limit), .load_low_sense(load_low_sense),
        .over_temp(over_temp), .supply_undervoltage_lockout(supply_low),
        .channel_on(channel_on));
    quad_lowside_controller #(.STARTUP_CYCLES(13'h0014))
        i_quad_lowside_controller (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    lowside_link_sva #(.STARTUP_CYCLES(13'h0014)) i_lowside_link_sva (
        .pclk(pclk), .presetn(presetn), .shift_clock(link.shift_clock),
        .latch(link.latch), .serial_data_in(link.serial_data_in),
        .chip_reset(link.chip_reset),
        .drive_enable_low(link.drive_enable_low),
        .serial_data_out(link.serial_data_out), .fault_n_o(link.fault_n_o),
        .fault_n_oe(link.fault_n_oe),
        .fault_indicator_n(link.fault_indicator_n));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            bad_count++;
            wrap_up();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end
        while (pready !== 1'b1 && n < 50);
        bound(n, 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin apb(1'b0, STATUS_ADDR, 32'h0); n++; end
        while (q[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
        bound(n, 3000);
    endtask
    // Write, latch and read back one frame; drv gives the drive-off level
    task automatic xfer(input logic [3:0] wd);
        int n;
        apb(1'b1, WDATA_ADDR, {28'h0, wd});
        apb(1'b1, CTRL_ADDR, {29'h0, drv, 2'h1});
        n = 0;
        while (link.latch !== 1'b1 && n < 400) begin @(posedge pclk); n++; end
        bound(n, 400);
        `CHK(link.serial_data_out, wd[3])
        wait_idle();
        apb(1'b0, RDATA_ADDR, 32'h0);
        rd = q[3:0];
    endtask
    task automatic trip(input int ch);
        current_limit[ch] <= 1'b1;
        repeat (430) @(posedge pclk);
        `CHK(channel_on[ch], 1'b1)
        repeat (20) @(posedge pclk);
        current_limit <= 4'h0;
        repeat (4) @(posedge pclk);
        `CHK(channel_on[ch], 1'b0)
        `CHK(link.fault_indicator_n, 1'b0)
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; current_limit = 4'h0;
        load_low_sense = 4'h0; over_temp = 1'b0; supply_low = 1'b0; drv = 1'b0;
        bad_count = 0; n_compared = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(channel_on, 4'h0)
        `CHK(link.serial_data_out, 1'b0)
        `CHK(link.fault_indicator_n, 1'b1)
        apb(1'b0, CTRL_ADDR, 32'h0);
        `CHK(q[CTRL_DRV_OFF_BIT], 1'b1)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        k = 0;
        do begin apb(1'b0, STATUS_ADDR, 32'h0); k++; end
        while (q[STAT_READY_BIT] !== 1'b1 && k < 100);
        bound(k, 100);
        $display("reset test done");
        foreach (rows[i]) begin
            drv = rows[i][8];
            xfer(rows[i][7:4]);
            `CHK(rd, 4'h0)
            `CHK(link.drive_enable_low, drv)
            `CHK(channel_on, rows[i][3:0])
        end
        $display("row tests done");
        xfer(4'h1);
        trip(0);
        xfer(4'h1);
        `CHK(rd, 4'h1)
        repeat (1500) @(posedge pclk);
        `CHK(channel_on[0], 1'b0)
        k = 0;
        while (channel_on[0] !== 1'b1 && k < 600) begin
            @(posedge pclk);
            k++;
        end
        bound(k, 600);
        `CHK(link.fault_indicator_n, 1'b1)
        xfer(4'h2);
        trip(1);
        xfer(4'h0);
        `CHK({rd, link.fault_indicator_n}, 5'h01)
        $display("overcurrent tests done");
        load_low_sense[2] <= 1'b1;
        repeat (1860) @(posedge pclk);
        `CHK(link.fault_indicator_n, 1'b1)
        repeat (40) @(posedge pclk);
        `CHK(link.fault_indicator_n, 1'b0)
        load_low_sense <= 4'h0;
        xfer(4'h0);
        `CHK(rd, 4'h4)
        xfer(4'h4);
        `CHK({rd, link.fault_indicator_n}, 5'h01)
        $display("open load test done");
        xfer(4'hF);
        over_temp <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK({channel_on, link.fault_indicator_n}, 5'h00)
        over_temp <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK({channel_on, link.fault_indicator_n}, 5'h1F)
        supply_low <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK(channel_on, 4'h0)
        supply_low <= 1'b0;
        repeat (30) @(posedge pclk);
        `CHK(channel_on, 4'h0)
        $display("shutdown tests done");
        xfer(4'h8);
        trip(3);
        apb(1'b1, CTRL_ADDR, {29'h0, drv, 2'h2});
        repeat (10) @(posedge pclk);
        `CHK(link.chip_reset, 1'b1)
        `CHK(link.fault_indicator_n, 1'b1)
        wait_idle();
        `CHK(channel_on, 4'h0)
        xfer(4'h3);
        `CHK({rd, channel_on}, 8'h03)
        $display("reset order test done");
        wrap_up();
    end
endmodule
`default_nettype wire
